/* File: logic/rsl_defs.vh */
/*
  offsets, field positions, reset values and decode constants of the
  receive sensitivity / signal level register bank.
  assumes an 8-bit register port with byte addresses as mapped below.
*/
`ifndef RSL_DEFS_VH
`define RSL_DEFS_VH

`define RSL_ADDR_W 8
`define RSL_DATA_W 8

`define RSL_OFF_SENSE_CH5_CH6 8'h0a
`define RSL_OFF_SENSE_CH7_CH8 8'h0b
`define RSL_OFF_LEVEL_CH1_CH2 8'h0c
`define RSL_OFF_SENSE_CH13_CH14 8'h2a
`define RSL_OFF_SENSE_CH15_CH16 8'h2b

`define RSL_RESET_VAL 8'h00
`define RSL_UNMAPPED_VAL 8'h00

`define RSL_ODD_SEL_LSB 0
`define RSL_ODD_TR_BIT 3
`define RSL_EVEN_SEL_LSB 4
`define RSL_EVEN_TR_BIT 7
`define RSL_LVL_ODD_LSB 0
`define RSL_LVL_EVEN_LSB 4

`define RSL_SEL_MONITOR_BIT 2
`define RSL_SEL_SENS_12DB 3'h0
`define RSL_SEL_SENS_18DB 3'h1
`define RSL_SEL_SENS_30DB 3'h2
`define RSL_SEL_SENS_MAX 3'h3
`define RSL_SEL_MON_14DB 3'h4
`define RSL_SEL_MON_20DB 3'h5
`define RSL_SEL_MON_26DB 3'h6
`define RSL_SEL_MON_32DB 3'h7

`define RSL_GAIN_0DB 6'h00
`define RSL_GAIN_14DB 6'h0e
`define RSL_GAIN_20DB 6'h14
`define RSL_GAIN_26DB 6'h1a
`define RSL_GAIN_32DB 6'h20

`endif

/* File: logic/rsl_chan_cfg.v */
/*
  one channel's receiver configuration decode: turns ratio select and
  sensitivity / monitor select field to analog front-end controls.
  assumes the caller holds the register bits; purely registered outputs.
*/
`timescale 1ns/10ps
`include "rsl_defs.vh"
module rsl_chan_cfg (
  mclk,
  rst,
  rx_turns_ratio_sel,
  rx_sense_gain_sel,
  long_haul_sel,
  ratio_one_to_one,
  monitor_en,
  flat_gain_db,
  sens_code,
  long_haul_en
);
  input wire mclk;
  input wire rst;
  input wire rx_turns_ratio_sel;
  input wire [2:0] rx_sense_gain_sel;
  input wire long_haul_sel;
  output reg ratio_one_to_one;
  output reg monitor_en;
  output reg [5:0] flat_gain_db;
  output reg [1:0] sens_code;
  output reg long_haul_en;

  reg [5:0] gain_next;

  always @* begin
    case (rx_sense_gain_sel)
      `RSL_SEL_MON_14DB: gain_next = `RSL_GAIN_14DB;
      `RSL_SEL_MON_20DB: gain_next = `RSL_GAIN_20DB;
      `RSL_SEL_MON_26DB: gain_next = `RSL_GAIN_26DB;
      `RSL_SEL_MON_32DB: gain_next = `RSL_GAIN_32DB;
      default: gain_next = `RSL_GAIN_0DB;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      ratio_one_to_one <= 1'b0;
      monitor_en <= 1'b0;
      flat_gain_db <= `RSL_GAIN_0DB;
      sens_code <= 2'h0;
      long_haul_en <= 1'b0;
    end else begin
      ratio_one_to_one <= rx_turns_ratio_sel;
      monitor_en <= rx_sense_gain_sel[`RSL_SEL_MONITOR_BIT];
      flat_gain_db <= gain_next;
      // low two bits pick 12/18/30/max dB sensitivity when monitor is off
      sens_code <= rx_sense_gain_sel[1:0];
      long_haul_en <= long_haul_sel;
    end
  end
endmodule

/* File: logic/rsl_level_cap.v */
/*
  capture of one channel's measured receive level code.
  assumes the measurement front end delivers a code synchronous to mclk.
*/
`timescale 1ns/10ps
module rsl_level_cap (
  mclk,
  rst,
  meas_valid,
  meas_code,
  rx_level_code
);
  input wire mclk;
  input wire rst;
  input wire meas_valid;
  input wire [3:0] meas_code;
  output reg [3:0] rx_level_code;

  // code 0 is above -2.5 dB, each step 2.5 dB lower, up to 4'hf
  always @(posedge mclk) begin
    if (rst) begin
      rx_level_code <= 4'h0;
    end else if (meas_valid) begin
      rx_level_code <= meas_code;
    end
  end
endmodule

/* File: logic/rsl_regs.v */
/*
  receive sensitivity and signal level register bank for channels 5..8
  and 13..16 sensitivity and channels 1/2 level, on an 8-bit register port.
  assumes a synchronous single-cycle port: write strobe with address and
  data, read strobe answered one cycle later with rd_valid.
*/
// Function
// - a set turns-ratio bit puts that channel's receiver in 1:1 mode.
// - each channel has a 3-bit select field, odd at bits 2:0, even at 6:4.
// - codes 0..3 give no flat gain and 12/18/30/max dB sensitivity.
// - codes 4..7 enable monitor mode with 14/20/26/32 dB flat gain.
// - each channel has a 4-bit level code, odd at 3:0, even at 7:4.
// - offset 0x0b holds channel 8 in the upper nibble and channel 7 in the lower.
// - offset 0x2a holds channel 14 upper and channel 13 lower.
// - offset 0x2b holds channel 16 upper and channel 15 lower.
// - offset 0x0c reports channel 2 level in 7:4 and channel 1 in 3:0.
// - channel 5 sits at bits 3 and 2:0 and channel 6 at 7 and 6:4 of offset 0x0a.
// - level code 0 is above -2.5 dB and each step is 2.5 dB lower.
// - a set long-haul select bit enables that channel's long-haul transmitter.
`timescale 1ns/10ps
`include "rsl_defs.vh"
module rsl_regs #(
  parameter NCH = 8
) (
  mclk,
  rst,
  reg_wr,
  reg_rd,
  reg_addr,
  reg_wdata,
  reg_rdata,
  reg_rd_valid,
  long_haul_sel,
  meas_valid,
  meas_code,
  ratio_one_to_one,
  monitor_en,
  flat_gain_db,
  sens_code,
  long_haul_en
);
  input wire mclk;
  input wire rst;
  input wire reg_wr;
  input wire reg_rd;
  input wire [`RSL_ADDR_W-1:0] reg_addr;
  input wire [`RSL_DATA_W-1:0] reg_wdata;
  output reg [`RSL_DATA_W-1:0] reg_rdata;
  output reg reg_rd_valid;
  input wire [NCH-1:0] long_haul_sel;
  input wire [1:0] meas_valid;
  input wire [7:0] meas_code;
  output wire [NCH-1:0] ratio_one_to_one;
  output wire [NCH-1:0] monitor_en;
  output wire [6*NCH-1:0] flat_gain_db;
  output wire [2*NCH-1:0] sens_code;
  output wire [NCH-1:0] long_haul_en;

  // channel order on the config vectors: 5,6,7,8,13,14,15,16
  reg [7:0] sense_ch5_ch6_reg;
  reg [7:0] rx_sense_ch7_ch8_reg;
  reg [7:0] rx_sense_ch13_ch14_reg;
  reg [7:0] rx_sense_ch15_ch16_reg;
  reg [7:0] rdata_next;
  wire [3:0] lvl_ch1;
  wire [3:0] lvl_ch2;
  wire [8*4-1:0] sense_bus;

  always @(posedge mclk) begin
    if (rst) begin
      sense_ch5_ch6_reg <= `RSL_RESET_VAL;
      rx_sense_ch7_ch8_reg <= `RSL_RESET_VAL;
      rx_sense_ch13_ch14_reg <= `RSL_RESET_VAL;
      rx_sense_ch15_ch16_reg <= `RSL_RESET_VAL;
    end else if (reg_wr) begin
      // level register at 0x0c is not decoded here, so writes to it drop
      case (reg_addr)
        `RSL_OFF_SENSE_CH5_CH6: sense_ch5_ch6_reg <= reg_wdata;
        `RSL_OFF_SENSE_CH7_CH8: rx_sense_ch7_ch8_reg <= reg_wdata;
        `RSL_OFF_SENSE_CH13_CH14: rx_sense_ch13_ch14_reg <= reg_wdata;
        `RSL_OFF_SENSE_CH15_CH16: rx_sense_ch15_ch16_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `RSL_OFF_SENSE_CH5_CH6: rdata_next = sense_ch5_ch6_reg;
      `RSL_OFF_SENSE_CH7_CH8: rdata_next = rx_sense_ch7_ch8_reg;
      `RSL_OFF_SENSE_CH13_CH14: rdata_next = rx_sense_ch13_ch14_reg;
      `RSL_OFF_SENSE_CH15_CH16: rdata_next = rx_sense_ch15_ch16_reg;
      `RSL_OFF_LEVEL_CH1_CH2: rdata_next = {lvl_ch2, lvl_ch1};
      default: rdata_next = `RSL_UNMAPPED_VAL;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= `RSL_RESET_VAL;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  rsl_level_cap u_lvl_ch1 (
    .mclk(mclk),
    .rst(rst),
    .meas_valid(meas_valid[0]),
    .meas_code(meas_code[3:0]),
    .rx_level_code(lvl_ch1)
  );

  rsl_level_cap u_lvl_ch2 (
    .mclk(mclk),
    .rst(rst),
    .meas_valid(meas_valid[1]),
    .meas_code(meas_code[7:4]),
    .rx_level_code(lvl_ch2)
  );

  // each register carries an odd channel nibble then an even one
  assign sense_bus = {rx_sense_ch15_ch16_reg, rx_sense_ch13_ch14_reg,
                      rx_sense_ch7_ch8_reg, sense_ch5_ch6_reg};

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      rsl_chan_cfg u_cfg (
        .mclk(mclk),
        .rst(rst),
        .rx_turns_ratio_sel(sense_bus[4*i+3]),
        .rx_sense_gain_sel(sense_bus[4*i+2:4*i]),
        .long_haul_sel(long_haul_sel[i]),
        .ratio_one_to_one(ratio_one_to_one[i]),
        .monitor_en(monitor_en[i]),
        .flat_gain_db(flat_gain_db[6*i+5:6*i]),
        .sens_code(sens_code[2*i+1:2*i]),
        .long_haul_en(long_haul_en[i])
      );
    end
  endgenerate
endmodule

/* File: verif/rsl_regs_monitor.sv */
/* port checker for the receive sensitivity / level register bank.
   assumes the one-cycle strobe port and registered config outputs. */
`timescale 1ns/10ps
module rsl_regs_chk #(parameter NCH = 8) (
  input wire mclk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rd_valid,
  input wire [NCH-1:0] long_haul_sel,
  input wire [1:0] meas_valid,
  input wire [7:0] meas_code,
  input wire [NCH-1:0] ratio_one_to_one,
  input wire [NCH-1:0] monitor_en,
  input wire [6*NCH-1:0] flat_gain_db,
  input wire [2*NCH-1:0] sens_code,
  input wire [NCH-1:0] long_haul_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // outputs lag the register by one edge, so a write shows two edges on
  a_read_answered: assert property (reg_rd |=> reg_rd_valid)
    else $error("read not answered");
  a_no_spurious_valid: assert property (!reg_rd |=> !reg_rd_valid)
    else $error("answer without read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ratio_ch8: assert property (reg_wr && reg_addr == 8'h0b
    |-> ##2 ratio_one_to_one[3] == $past(reg_wdata[7], 2)) else $error("ch8 ratio");
  a_ratio_ch7: assert property (reg_wr && reg_addr == 8'h0b
    |-> ##2 ratio_one_to_one[2] == $past(reg_wdata[3], 2)) else $error("ch7 ratio");
  a_monitor_ch13: assert property (reg_wr && reg_addr == 8'h2a
    |-> ##2 monitor_en[4] == $past(reg_wdata[2], 2)) else $error("ch13 monitor");
  a_sense_ch16: assert property (reg_wr && reg_addr == 8'h2b
    |-> ##2 sens_code[15:14] == $past(reg_wdata[5:4], 2)) else $error("ch16 sense");
  a_gain_ch5: assert property (reg_wr && reg_addr == 8'h0a |-> ##2
    flat_gain_db[5:0] == ($past(reg_wdata[2], 2) ? 6'h0e + 6'h06 * $past(reg_wdata[1:0], 2)
    : 6'h00)) else $error("ch5 gain");
  a_long_haul_copy: assert property (!$past(rst) |-> long_haul_en == $past(long_haul_sel))
    else $error("long haul copy");
  c_read: cover property (reg_rd ##1 reg_rd_valid);
  c_level_wr: cover property (reg_wr && reg_addr == 8'h0c);
  c_meas: cover property (meas_valid != 2'b00);
endmodule
bind rsl_regs rsl_regs_chk #(.NCH(NCH)) u_chk (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .long_haul_sel(long_haul_sel), .meas_valid(meas_valid),
  .meas_code(meas_code), .ratio_one_to_one(ratio_one_to_one), .monitor_en(monitor_en),
  .flat_gain_db(flat_gain_db), .sens_code(sens_code), .long_haul_en(long_haul_en));

/* File: verif/tb_top.sv */
/* self-checking bench for rsl_regs through its strobe port.
   assumes 100 MHz mclk and read answers one cycle after the strobe. */
`timescale 1ns/10ps
module tb_top;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg [7:0] long_haul_sel = 8'h00;
  reg [1:0] meas_valid = 2'b00;
  reg [7:0] meas_code = 8'h00;
  wire [7:0] reg_rdata;
  wire reg_rd_valid;
  wire [7:0] ratio_one_to_one, monitor_en, long_haul_en;
  wire [47:0] flat_gain_db;
  wire [15:0] sens_code;
  integer err_total = 0;
  integer checked = 0;
  integer i;
  reg [5:0] g;
  // 0x0c is read-only and 0x33 unmapped: both must read back zero
  reg [47:0] offs = 48'h0a0b0c2a2b33;
  reg [47:0] vals = 48'ha795ff5ee35a;
  rsl_regs #(.NCH(8)) dut_u (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .long_haul_sel(long_haul_sel), .meas_valid(meas_valid),
    .meas_code(meas_code), .ratio_one_to_one(ratio_one_to_one), .monitor_en(monitor_en),
    .flat_gain_db(flat_gain_db), .sens_code(sens_code), .long_haul_en(long_haul_en));
  initial forever #5 mclk = ~mclk;
  task complete_run;
    begin
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk({7'h00, reg_rd_valid}, 8'h01);
      chk(reg_rdata, e);
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 6; i = i + 1) rd(offs[47-8*i -: 8], 8'h00);
    for (i = 0; i < 6; i = i + 1) wr(offs[47-8*i -: 8], vals[47-8*i -: 8]);
    for (i = 0; i < 6; i = i + 1) begin
      rd(offs[47-8*i -: 8], (i == 2 || i == 5) ? 8'h00 : vals[47-8*i -: 8]);
    end
    settle;
    chk(ratio_one_to_one, 8'h9a);
    chk(monitor_en, 8'hb5);
    chk(sens_code[7:0], 8'h5b);
    chk(sens_code[15:8], 8'hb6);
    chk({2'h0, flat_gain_db[17:12]}, 8'h14);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h0a, {1'b0, i[2:0], 1'b0, i[2:0]});
      settle;
      g = i[2] ? 6'h0e + 6'h06 * i[1:0] : 6'h00;
      chk({2'h0, flat_gain_db[5:0]}, {2'h0, g});
      chk({2'h0, flat_gain_db[11:6]}, {2'h0, g});
      chk({2'h0, monitor_en[1:0], sens_code[3:0]}, {2'h0, {2{i[2]}}, i[1:0], i[1:0]});
    end
    @(posedge mclk);
    meas_valid <= 2'b01;
    meas_code <= 8'h3c;
    @(posedge mclk);
    meas_valid <= 2'b10;
    meas_code <= 8'hf0;
    @(posedge mclk);
    meas_valid <= 2'b00;
    meas_code <= 8'h11;
    long_haul_sel <= 8'ha5;
    rd(8'h0c, 8'hfc);
    chk(long_haul_en, 8'ha5);
    // long-haul channels 5, 7, 14, 16 get the 1:1 bit; channel 15 gets it too without long haul
    wr(8'h0a, 8'h08);
    wr(8'h0b, 8'h08);
    wr(8'h2a, 8'h80);
    wr(8'h2b, 8'h88);
    settle;
    chk(ratio_one_to_one, 8'he5);
    chk(monitor_en, 8'h00);
    chk({2'h0, flat_gain_db[47:42]}, 8'h00);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'hfc);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h2b, 8'h00);
    rd(8'h0c, 8'h00);
    chk(ratio_one_to_one, 8'h00);
    complete_run;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    err_total = err_total + 1;
    complete_run;
  end
endmodule
